// [rtl/igc_config_gc.sv]
// Purpose: Lower configuration bits of an I2C controller with general call handling.
// Assumes: Bus pins are open drain and synchronous to core_clk; the byte engine is outside.
// Notes: The master byte engine drives mstSclLow and mstSdaLow and reports mstArbLost.
//
// Function
// - Loopback bit routes own transmit into receive.
// - Backoff disabled: retry at once after arbitration loss.
// - Backoff enabled: wait before retrying after loss.
// - Hardware general call: data byte matches alternate ID.
// - General call enable: acknowledge address zero, take byte.
// - Byte 0x06 resets the I2C interface.
// - Byte 0x04 flags address reprogramming for software.
// - Any enabled general call sets its status flag.
// - Bit 1 enables the master channel.
// - Bit 0 enables the slave channel.
// - Slave compares address against all four IDs.
// - Bit 7 enables master serial clock generation.
`timescale 1ns/100ps
module igc_config_gc
    import igc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] cfgWord,
    input wire logic [7:0] slaveMatchIdA,
    input wire logic [7:0] slaveMatchIdB,
    input wire logic [7:0] slaveMatchIdC,
    input wire logic [7:0] slaveMatchIdD,
    input wire logic [7:0] altGeneralCallId,
    input wire logic gcStatusClear,
    input wire logic mstStartReq,
    input wire logic mstArbLost,
    input wire logic mstSclLow,
    input wire logic mstSdaLow,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sclOut,
    output logic sclOe,
    output logic sdaOut,
    output logic sdaOe,
    output logic [7:0] cfgEcho,
    output logic mstStartOk,
    output logic mstSdaSeen,
    output logic slaveAddrHit,
    output logic [1:0] slaveHitIdx,
    output logic gcStatus,
    output logic hwGcStatus,
    output logic addrProgStatus,
    output logic [7:0] gcData,
    output logic ifaceReset
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [7:0] cfgEcho;
        logic sclOut;
        logic sclOe;
        logic sdaOut;
        logic sdaOe;
        igc_mst_state_t mstState;
        logic [7:0] backoffCnt;
        logic mstStartOk;
        logic mstSdaSeen;
        logic slaveAddrHit;
        logic [1:0] slaveHitIdx;
        logic gcStatus;
        logic hwGcStatus;
        logic addrProgStatus;
        logic [7:0] gcData;
        logic ifaceReset;
    } igc_core_st_t;

    igc_core_st_t st_reg;
    igc_core_st_t st_next;
    logic loopback;
    logic backoffDis;
    logic hwGcEn;
    logic gcEn;
    logic masterEn;
    logic slaveEn;
    logic sclEn;
    logic sclViewLocal;
    logic sdaViewLocal;

    igc_rx_if link ();

    // ****************************************************************
    // Configuration decode
    // ****************************************************************
    // Bit 2 is never decoded, so it cannot steer anything.
    assign loopback = cfgWord[CFG_LOOPBACK_BIT];
    assign backoffDis = cfgWord[CFG_BACKOFF_DIS_BIT];
    assign hwGcEn = cfgWord[CFG_HW_GC_EN_BIT];
    assign gcEn = cfgWord[CFG_GC_EN_BIT];
    assign masterEn = cfgWord[CFG_MASTER_EN_BIT];
    assign slaveEn = cfgWord[CFG_SLAVE_EN_BIT];
    assign sclEn = cfgWord[CFG_SCL_EN_BIT];

    // In loopback the receive path sees our own drivers instead of the pins.
    // The pins are released meanwhile so a self test never disturbs other bus users.
    assign sclViewLocal = loopback ? ~(masterEn & sclEn & mstSclLow) : sclIn;
    assign sdaViewLocal = loopback ? ~((masterEn & mstSdaLow) | link.ackDrive) : sdaIn;

    // Settings handed to the slave receiver.
    assign link.sclView = sclViewLocal;
    assign link.sdaView = sdaViewLocal;
    assign link.slaveEn = slaveEn;
    assign link.gcEn = gcEn;
    assign link.softRst = st_reg.ifaceReset;
    assign link.ids = {slaveMatchIdD, slaveMatchIdC, slaveMatchIdB, slaveMatchIdA};

    igc_slave_rx u_rx (
        .core_clk(core_clk),
        .rstn(rstn),
        .link(link)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic gcSet;
        logic hwMatch;
        st_next = st_reg;
        gcSet = 1'b0;
        hwMatch = 1'b0;

        // Echo of the configuration with the reserved bit forced low.
        st_next.cfgEcho = cfgWord;
        st_next.cfgEcho[CFG_RESERVED_BIT] = 1'b0;

        // Open-drain pins: output level is always low, enable means pulling down.
        st_next.sclOut = 1'b0;
        st_next.sdaOut = 1'b0;
        st_next.sclOe = ~loopback & masterEn & sclEn & mstSclLow;
        st_next.sdaOe = ~loopback & ((masterEn & mstSdaLow) | link.ackDrive);
        st_next.mstSdaSeen = sdaViewLocal;

        // Master start permission with optional backoff after lost arbitration.
        if (!masterEn || st_reg.ifaceReset) begin
            st_next.mstState = MST_IDLE;
            st_next.mstStartOk = 1'b0;
        end else begin
            unique case (st_reg.mstState)
                MST_IDLE: begin
                    if (mstStartReq) begin
                        st_next.mstState = MST_RUN;
                        st_next.mstStartOk = 1'b1;
                    end
                end
                MST_RUN: begin
                    if (!mstStartReq) begin
                        st_next.mstState = MST_IDLE;
                        st_next.mstStartOk = 1'b0;
                    end else if (mstArbLost && backoffDis) begin
                        st_next.mstStartOk = 1'b1;
                    end else if (mstArbLost) begin
                        st_next.mstState = MST_BACKOFF;
                        st_next.mstStartOk = 1'b0;
                        st_next.backoffCnt = BACKOFF_LOAD;
                    end
                end
                MST_BACKOFF: begin
                    if (st_reg.backoffCnt != 8'h00) begin
                        st_next.backoffCnt = st_reg.backoffCnt - 8'h01;
                    end else if (mstStartReq) begin
                        st_next.mstState = MST_RUN;
                        st_next.mstStartOk = 1'b1;
                    end else begin
                        st_next.mstState = MST_IDLE;
                    end
                end
                default: begin
                    st_next.mstState = MST_IDLE;
                    st_next.mstStartOk = 1'b0;
                end
            endcase
        end

        // Slave address match reporting, one cycle per matched address.
        st_next.slaveAddrHit = link.addrHit;
        if (link.addrHit) begin
            st_next.slaveHitIdx = link.hitIdx;
        end

        // General call byte handling; the hardware call check has priority over the codes.
        st_next.ifaceReset = 1'b0;
        if (link.gcByteValid) begin
            st_next.gcData = link.gcByte;
            hwMatch = hwGcEn && link.gcByte == altGeneralCallId;
        end
        gcSet = link.gcAddr;

        // Clearing is done first so that a same-cycle event still sets its flag.
        if (gcStatusClear) begin
            st_next.gcStatus = 1'b0;
            st_next.hwGcStatus = 1'b0;
            st_next.addrProgStatus = 1'b0;
        end
        if (gcSet) begin
            st_next.gcStatus = 1'b1;
        end
        if (hwMatch) begin
            st_next.hwGcStatus = 1'b1;
        end else if (link.gcByteValid && link.gcByte == GC_CMD_RESET) begin
            st_next.ifaceReset = 1'b1;
        end else if (link.gcByteValid && link.gcByte == GC_CMD_PROG) begin
            st_next.addrProgStatus = 1'b1;
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '{cfgEcho: CFG_RESET_VALUE, mstState: MST_IDLE, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign sclOut = st_reg.sclOut;
    assign sclOe = st_reg.sclOe;
    assign sdaOut = st_reg.sdaOut;
    assign sdaOe = st_reg.sdaOe;
    assign cfgEcho = st_reg.cfgEcho;
    assign mstStartOk = st_reg.mstStartOk;
    assign mstSdaSeen = st_reg.mstSdaSeen;
    assign slaveAddrHit = st_reg.slaveAddrHit;
    assign slaveHitIdx = st_reg.slaveHitIdx;
    assign gcStatus = st_reg.gcStatus;
    assign hwGcStatus = st_reg.hwGcStatus;
    assign addrProgStatus = st_reg.addrProgStatus;
    assign gcData = st_reg.gcData;
    assign ifaceReset = st_reg.ifaceReset;

endmodule

// [rtl/igc_pkg.sv]
// Purpose: Shared constants and types for the I2C configuration and general call block.
// Assumes: Core clock of 40 MHz, open-drain bus pins sampled synchronously.
// Notes: Field positions index the 8-bit configuration word presented on cfgWord.
package igc_pkg;

    // ****************************************************************
    // Configuration word field positions
    // ****************************************************************
    localparam int CFG_SLAVE_EN_BIT = 0;
    localparam int CFG_MASTER_EN_BIT = 1;
    localparam int CFG_RESERVED_BIT = 2;
    localparam int CFG_GC_EN_BIT = 3;
    localparam int CFG_HW_GC_EN_BIT = 4;
    localparam int CFG_BACKOFF_DIS_BIT = 5;
    localparam int CFG_LOOPBACK_BIT = 6;
    localparam int CFG_SCL_EN_BIT = 7;
    localparam logic [7:0] CFG_RESET_VALUE = 8'h00;

    // ****************************************************************
    // General call codes
    // ****************************************************************
    localparam logic [7:0] GC_ADDR_BYTE = 8'h00;
    localparam logic [7:0] GC_CMD_RESET = 8'h06;
    localparam logic [7:0] GC_CMD_PROG = 8'h04;
    localparam int NUM_SLAVE_IDS = 4;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 25;
    localparam int BACKOFF_NS = 2500;
    localparam int BACKOFF_CYCLES = (BACKOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] BACKOFF_LOAD = 8'(BACKOFF_CYCLES - 1);

    // ****************************************************************
    // State encodings
    // ****************************************************************
    typedef enum logic [2:0] {
        RX_IDLE = 3'b000,
        RX_ADDR = 3'b001,
        RX_AACK = 3'b010,
        RX_DATA = 3'b011,
        RX_DACK = 3'b100,
        RX_SKIP = 3'b101
    } igc_rx_state_t;

    typedef enum logic [1:0] {
        MST_IDLE = 2'b00,
        MST_RUN = 2'b01,
        MST_BACKOFF = 2'b10
    } igc_mst_state_t;

endpackage

// [rtl/igc_rx_if.sv]
// Purpose: Carrier between the configuration core and the slave receiver.
// Assumes: Both ends run on core_clk.
// Notes: The core owns the bus view and settings, the receiver owns the events.
`timescale 1ns/100ps
interface igc_rx_if;
    logic sclView;
    logic sdaView;
    logic slaveEn;
    logic gcEn;
    logic softRst;
    logic [3:0][7:0] ids;
    logic ackDrive;
    logic addrHit;
    logic [1:0] hitIdx;
    logic gcAddr;
    logic gcByteValid;
    logic [7:0] gcByte;

    modport core (output sclView, sdaView, slaveEn, gcEn, softRst, ids,
                  input ackDrive, addrHit, hitIdx, gcAddr, gcByteValid, gcByte);
    modport rx (input sclView, sdaView, slaveEn, gcEn, softRst, ids,
                output ackDrive, addrHit, hitIdx, gcAddr, gcByteValid, gcByte);
endinterface

// [rtl/igc_slave_rx.sv]
// Purpose: Slave address receiver with general call byte capture.
// Assumes: sclView and sdaView are already synchronous to core_clk.
// Notes: A matched device address is acknowledged and the rest of the transfer skipped.
`timescale 1ns/100ps
module igc_slave_rx
    import igc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    igc_rx_if.rx link
);

    typedef struct packed {
        igc_rx_state_t state;
        logic sclPrev;
        logic sdaPrev;
        logic [7:0] shift;
        logic [2:0] bitCnt;
        logic ackDrive;
        logic isGc;
        logic addrHit;
        logic [1:0] hitIdx;
        logic gcAddr;
        logic gcByteValid;
    } igc_rx_st_t;

    igc_rx_st_t rx_reg;
    igc_rx_st_t rx_next;
    logic [7:0] newByte;
    logic [NUM_SLAVE_IDS-1:0] idHit;

    assign newByte = {rx_reg.shift[6:0], link.sdaView};

    // Each ID holds a 7-bit address in its low bits; compare it with the address field.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SLAVE_IDS; gi++) begin : g_id
            assign idHit[gi] = (newByte[7:1] == link.ids[gi][6:0]);
        end
    endgenerate

    // Bus event decode, bit shifting and the acknowledge slot.
    always_comb begin
        logic rise;
        logic fall;
        logic start;
        logic stop;
        rise = ~rx_reg.sclPrev & link.sclView;
        fall = rx_reg.sclPrev & ~link.sclView;
        start = rx_reg.sclPrev & link.sclView & rx_reg.sdaPrev & ~link.sdaView;
        stop = rx_reg.sclPrev & link.sclView & ~rx_reg.sdaPrev & link.sdaView;
        rx_next = rx_reg;
        rx_next.sclPrev = link.sclView;
        rx_next.sdaPrev = link.sdaView;
        rx_next.addrHit = 1'b0;
        rx_next.gcAddr = 1'b0;
        rx_next.gcByteValid = 1'b0;
        if (link.softRst || !link.slaveEn) begin
            rx_next.state = RX_IDLE;
            rx_next.ackDrive = 1'b0;
        end else if (start) begin
            rx_next.state = RX_ADDR;
            rx_next.bitCnt = 3'h0;
            rx_next.ackDrive = 1'b0;
        end else if (stop) begin
            rx_next.state = RX_IDLE;
            rx_next.ackDrive = 1'b0;
        end else begin
            unique case (rx_reg.state)
                RX_IDLE, RX_SKIP: begin
                end
                RX_ADDR, RX_DATA: begin
                    if (rise) begin
                        rx_next.shift = newByte;
                        rx_next.bitCnt = rx_reg.bitCnt + 3'h1;
                        if (rx_reg.bitCnt == 3'h7 && rx_reg.state == RX_DATA) begin
                            rx_next.state = RX_DACK;
                            rx_next.gcByteValid = 1'b1;
                        end else if (rx_reg.bitCnt == 3'h7) begin
                            rx_next.isGc = link.gcEn && newByte == GC_ADDR_BYTE;
                            rx_next.gcAddr = link.gcEn && newByte == GC_ADDR_BYTE;
                            rx_next.addrHit = |idHit;
                            rx_next.hitIdx = idHit[0] ? 2'h0 : idHit[1] ? 2'h1 :
                                             idHit[2] ? 2'h2 : 2'h3;
                            rx_next.state = ((link.gcEn && newByte == GC_ADDR_BYTE) || |idHit)
                                            ? RX_AACK : RX_SKIP;
                        end
                    end
                end
                RX_AACK, RX_DACK: begin
                    // Pull SDA from the eighth falling edge to the ninth.
                    if (fall && !rx_reg.ackDrive) begin
                        rx_next.ackDrive = 1'b1;
                    end else if (fall) begin
                        rx_next.ackDrive = 1'b0;
                        rx_next.bitCnt = 3'h0;
                        rx_next.state = (rx_reg.state == RX_AACK && rx_reg.isGc) ? RX_DATA
                                                                                 : RX_SKIP;
                    end
                end
                default: begin
                    rx_next.state = RX_IDLE;
                end
            endcase
        end
    end

    // State register.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rx_reg <= '{state: RX_IDLE, sclPrev: 1'b1, sdaPrev: 1'b1, default: '0};
        end else begin
            rx_reg <= rx_next;
        end
    end

    assign link.ackDrive = rx_reg.ackDrive;
    assign link.addrHit = rx_reg.addrHit;
    assign link.hitIdx = rx_reg.hitIdx;
    assign link.gcAddr = rx_reg.gcAddr;
    assign link.gcByteValid = rx_reg.gcByteValid;
    assign link.gcByte = rx_reg.shift;

endmodule

// [testbench/igc_config_gc_properties.sv]
// Purpose: Concurrent checks on the ports of the configuration and general call block.
// Assumes: One core_clk domain with asynchronous active-low rstn.
// Notes: Bound into every igc_config_gc instance below.
`timescale 1ns/100ps
module igc_config_gc_properties
    import igc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] cfgWord,
    input wire logic [7:0] altGeneralCallId,
    input wire logic mstStartReq,
    input wire logic mstArbLost,
    input wire logic mstSclLow,
    input wire logic sclOe,
    input wire logic sdaOe,
    input wire logic [7:0] cfgEcho,
    input wire logic mstStartOk,
    input wire logic slaveAddrHit,
    input wire logic gcStatus,
    input wire logic hwGcStatus,
    input wire logic addrProgStatus,
    input wire logic [7:0] gcData,
    input wire logic ifaceReset
);
    // ****************************************************************
    // Clocking and sequences
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // An arbitration loss while the master holds permission and backoff is on.
    sequence sLoss;
        mstStartOk && mstArbLost && !cfgWord[CFG_BACKOFF_DIS_BIT];
    endsequence
    // The first stretch of the backoff wait, where permission stays withdrawn.
    sequence sHeldOff;
        !mstStartOk [*8];
    endsequence

    // ****************************************************************
    // Assertions
    // ****************************************************************
    // Guards on $past(rstn) skip the edge whose history lies inside reset.
    AST_ECHO: assert property ($past(rstn) |-> cfgEcho == ($past(cfgWord) & 8'hfb))
        else $error("cfgEcho does not follow cfgWord");
    AST_RSV_ZERO: assert property (cfgEcho[CFG_RESERVED_BIT] == 1'b0)
        else $error("reserved bit reads one");
    AST_SCL_OE: assert property ($past(rstn) |-> sclOe == $past(!cfgWord[6] &&
        cfgWord[1] && cfgWord[7] && mstSclLow)) else $error("sclOe wrong");
    AST_LOOP_REL: assert property ($past(cfgWord[CFG_LOOPBACK_BIT]) |-> !sclOe && !sdaOe)
        else $error("pins driven in loopback");
    AST_MST_DIS: assert property ($past(rstn) && !$past(cfgWord[1]) |-> !mstStartOk)
        else $error("permission with master disabled");
    AST_NO_BACKOFF: assert property (mstStartOk && mstArbLost && cfgWord[5] &&
        cfgWord[1] && mstStartReq && !ifaceReset |=> mstStartOk) else $error("retry held off");
    AST_BACKOFF: assert property (sLoss |=> sHeldOff)
        else $error("retry without backoff");
    AST_GC_EN: assert property ($rose(gcStatus) |-> $past(cfgWord[3] && cfgWord[0], 2))
        else $error("general call flag while disabled");
    AST_HW_GC: assert property ($rose(hwGcStatus) |-> gcData == altGeneralCallId &&
        $past(cfgWord[CFG_HW_GC_EN_BIT])) else $error("hardware call without match");
    AST_PROG: assert property ($rose(addrProgStatus) |-> gcData == GC_CMD_PROG)
        else $error("program flag with wrong byte");
    AST_IFR: assert property (ifaceReset |-> (gcData == GC_CMD_RESET) ##1 !ifaceReset)
        else $error("interface reset wrong");
    AST_SLV_EN: assert property (slaveAddrHit |-> $past(cfgWord[CFG_SLAVE_EN_BIT], 2))
        else $error("address hit with slave disabled");
endmodule

bind igc_config_gc igc_config_gc_properties u_props (
    .core_clk, .rstn, .cfgWord, .altGeneralCallId, .mstStartReq, .mstArbLost, .mstSclLow,
    .sclOe, .sdaOe, .cfgEcho, .mstStartOk, .slaveAddrHit, .gcStatus, .hwGcStatus,
    .addrProgStatus, .gcData, .ifaceReset
);

// [testbench/igc_bus_master_model.sv]
// Purpose: Behavioural remote I2C master on the shared bus.
// Assumes: Lines are open drain with pull-ups, so a released line reads high.
// Notes: SCL stands high between frames; SDA moves while SCL is low, except at start and stop where it moves with SCL high.
`timescale 1ns/100ps
module igc_bus_master_model #(
    parameter int HALF = 8
) (
    input wire logic core_clk,
    input wire logic sdaLine,
    output logic sclDrv,
    output logic sdaDrv
);
    // Both lines released at time zero.
    initial begin
        sclDrv = 1'b1;
        sdaDrv = 1'b1;
    end

    // Waits n core cycles, then steps off the edge.
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask

    // Start: SDA falls while SCL is high.
    task automatic start_cond();
        sdaDrv = 1'b1;
        sclDrv = 1'b1;
        wait_cyc(HALF);
        sdaDrv = 1'b0;
        wait_cyc(HALF);
        sclDrv = 1'b0;
        wait_cyc(1);
    endtask

    // One byte MSB first, then a released ninth clock for the slave's answer.
    task automatic send_byte(input logic [7:0] val, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sdaDrv = val[i];
            wait_cyc(HALF);
            sclDrv = 1'b1;
            wait_cyc(HALF);
            sclDrv = 1'b0;
            wait_cyc(1);
        end
        sdaDrv = 1'b1;
        wait_cyc(HALF);
        sclDrv = 1'b1;
        wait_cyc(HALF);
        ack = !sdaLine;
        sclDrv = 1'b0;
        wait_cyc(HALF);
    endtask

    // Stop: SDA rises while SCL is high.
    task automatic stop_cond();
        sdaDrv = 1'b0;
        wait_cyc(HALF);
        sclDrv = 1'b1;
        wait_cyc(HALF);
        sdaDrv = 1'b1;
        wait_cyc(HALF);
    endtask
endmodule

// [testbench/testbench.sv]
// Purpose: Self-checking bench for the configuration and general call block.
// Assumes: 40 MHz core_clk, inputs driven 2 ns after the rising edge.
// Notes: A remote master model drives the bus.
`timescale 1ns/100ps
module testbench;
    import igc_pkg::*;
    logic core_clk = 1'b0, rstn = 1'b0, gcStatusClear = 1'b0, mstStartReq = 1'b0;
    logic mstArbLost = 1'b0, mstSclLow = 1'b0, mstSdaLow = 1'b0;
    logic [7:0] cfgWord = 8'h00, altGeneralCallId = 8'h55;
    logic [7:0] ids [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
    logic sclDrv, sdaDrv, sclOut, sclOe, sdaOut, sdaOe, mstStartOk, mstSdaSeen;
    logic slaveAddrHit, gcStatus, hwGcStatus, addrProgStatus, ifaceReset;
    logic hitSeen = 1'b0, ifrSeen = 1'b0;
    logic [1:0] slaveHitIdx, idxSeen;
    logic [7:0] cfgEcho, gcData;
    wire sclIn = sclDrv & !sclOe;
    wire sdaIn = sdaDrv & !sdaOe;
    int errors = 0, nCompared = 0, cycles = 0;

    igc_config_gc i_dut (.core_clk, .rstn, .cfgWord, .slaveMatchIdA(ids[0]),
        .slaveMatchIdB(ids[1]), .slaveMatchIdC(ids[2]), .slaveMatchIdD(ids[3]),
        .altGeneralCallId, .gcStatusClear, .mstStartReq, .mstArbLost, .mstSclLow, .mstSdaLow,
        .sclIn, .sdaIn, .sclOut, .sclOe, .sdaOut, .sdaOe, .cfgEcho, .mstStartOk, .mstSdaSeen,
        .slaveAddrHit, .slaveHitIdx, .gcStatus, .hwGcStatus, .addrProgStatus, .gcData,
        .ifaceReset);
    igc_bus_master_model i_bus (.core_clk, .sdaLine(sdaIn), .sclDrv, .sdaDrv);

    // Clock, one-cycle event capture and the hang limit.
    initial forever #12.5 core_clk = !core_clk;
    always @(posedge core_clk) begin
        if (slaveAddrHit === 1'b1) {hitSeen, idxSeen} <= {1'b1, slaveHitIdx};
        if (ifaceReset === 1'b1) ifrSeen <= 1'b1;
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            errors++;
            wrap_up();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask
    task automatic chk1(input string what, input logic exp, input logic got);
        nCompared++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        nCompared++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One framed write; the data byte is sent only when asked.
    task automatic frame(input logic [7:0] adr, input logic two, input logic [7:0] dat,
        output logic ackA, output logic ackD);
        {hitSeen, ifrSeen} = 2'b00;
        ackD = 1'b0;
        i_bus.start_cond();
        i_bus.send_byte(adr, ackA);
        if (two) i_bus.send_byte(dat, ackD);
        i_bus.stop_cond();
        tick(2);
    endtask
    task automatic clear_flags();
        gcStatusClear = 1'b1;
        tick(1);
        gcStatusClear = 1'b0;
        tick(1);
    endtask

    // The reserved bit never reaches the echo.
    task automatic t_echo();
        chk8("echo reset", 8'h00, cfgEcho);
        cfgWord = 8'h7c;
        tick(2);
        chk8("echo", 8'h78, cfgEcho);
        cfgWord = 8'h00;
        tick(2);
        $display("test echo done");
    endtask
    // Every ID answers with its index; a stranger or a disabled slave is ignored.
    task automatic t_slave();
        logic a, d;
        cfgWord = 8'h01;
        for (int i = 0; i < 4; i++) begin
            frame({ids[i][6:0], 1'b0}, 1'b0, 8'h00, a, d);
            chk1("id ack", 1'b1, a);
            chk1("id hit", 1'b1, hitSeen);
            chk8("id index", 8'(i), 8'(idxSeen));
        end
        frame(8'hfc, 1'b0, 8'h00, a, d);
        chk1("stranger ack", 1'b0, a);
        cfgWord = 8'h00;
        frame({ids[0][6:0], 1'b0}, 1'b0, 8'h00, a, d);
        chk1("disabled ack", 1'b0, a);
        $display("test slave done");
    endtask
    // General call codes, hardware match and a disabled general call.
    task automatic t_gcall();
        logic a, d;
        cfgWord = 8'h09;
        frame(GC_ADDR_BYTE, 1'b1, GC_CMD_PROG, a, d);
        chk1("gc ack", 1'b1, a);
        chk1("gc flag", 1'b1, gcStatus);
        chk1("prog flag", 1'b1, addrProgStatus);
        chk8("gc data", GC_CMD_PROG, gcData);
        clear_flags();
        chk1("cleared", 1'b0, gcStatus);
        frame(GC_ADDR_BYTE, 1'b1, GC_CMD_RESET, a, d);
        chk1("iface reset", 1'b1, ifrSeen);
        clear_flags();
        cfgWord = 8'h19; // Bit 4 adds the hardware general call; the odd word keeps slave enable at one.
        frame(GC_ADDR_BYTE, 1'b1, altGeneralCallId, a, d);
        chk1("hw gc flag", 1'b1, hwGcStatus);
        chk1("no prog flag", 1'b0, addrProgStatus);
        clear_flags();
        cfgWord = 8'h01;
        frame(GC_ADDR_BYTE, 1'b1, GC_CMD_PROG, a, d);
        chk1("gc off ack", 1'b0, a);
        chk1("gc off flag", 1'b0, gcStatus);
        $display("test general call done");
    endtask
    // Retry after arbitration loss with backoff off and on, then disable.
    task automatic t_master();
        int n;
        cfgWord = 8'h22;
        mstStartReq = 1'b1;
        tick(3);
        chk1("start ok", 1'b1, mstStartOk);
        mstArbLost = 1'b1;
        tick(1);
        mstArbLost = 1'b0;
        tick(1);
        chk1("no backoff", 1'b1, mstStartOk);
        cfgWord = 8'h02;
        tick(1);
        mstArbLost = 1'b1;
        tick(1);
        mstArbLost = 1'b0;
        for (n = 0; n < 200 && mstStartOk !== 1'b1; n++) tick(1);
        chk1("backoff", 1'b1, n >= BACKOFF_CYCLES - 1 && n <= BACKOFF_CYCLES + 3);
        cfgWord = 8'h00;
        tick(2);
        chk1("disabled", 1'b0, mstStartOk);
        mstStartReq = 1'b0;
        $display("test master done");
    endtask
    // Clock enable gates SCL; loopback releases the SDA pin and feeds own SDA back.
    task automatic t_pins();
        {mstSclLow, mstSdaLow} = 2'b11;
        cfgWord = 8'h82;
        tick(2);
        chk1("scl drive", 1'b1, sclOe);
        chk1("sda drive", 1'b1, sdaOe);
        cfgWord = 8'h02;
        tick(2);
        chk1("scl gated", 1'b0, sclOe);
        cfgWord = 8'hc2;
        tick(3);
        chk1("loop sda pin", 1'b0, sdaOe);
        chk1("loop sda seen", 1'b0, mstSdaSeen);
        mstSdaLow = 1'b0;
        tick(3);
        chk1("loop sda high", 1'b1, mstSdaSeen);
        chk1("pin levels", 1'b0, sclOut | sdaOut);
        {mstSclLow, cfgWord} = 9'h000;
        $display("test pins done");
    endtask

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", nCompared, errors);
        if (errors == 0 && nCompared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        tick(20);
        rstn = 1'b1;
        tick(2);
        t_echo();
        t_slave();
        t_gcall();
        t_master();
        t_pins();
        wrap_up();
    end
endmodule
